/* File: design/txm_pkg.sv */
// package of constants and types shared by the mode controller and its host driver
// Contract
// - long enable low resets all, enters power-down; code clears only the synth power-on bit, other control bits kept
// - timeout power-down clears synth power-on bit
// - power-down request bit forces power-down anywhere
// - enable rising edge clears power-down request
// - enable rise in power-down starts crystal mode
// - host waits oscillator settling before synth on
// - synth power-on bit enters synth-active mode
// - synth mode holds until timeout or request
// - clearing synth bit returns to crystal mode
// - transmit command accepted only with synth on
// - enable low ends transmit, direct or synced
// - stop write, reset, power fail give crystal
// - transmit ends in power-down on request/timeout
// - enable pulse opens access, data held
// - host resends transmit command to resume
// - amplifier on, baud generator reset at start
// - baud generator keeps phase across resume
// - supply drop clears synth bit, host restarts
// - regulated oscillator supply only while transmitting
// - amplifier mode field bits 3:2, mode 3 unregulated
// - enable fall latches data pin to modulator
`default_nettype none
package txm_pkg;
    // register map
    localparam logic [5:0] TXM_ADDR_TX_CONTROL = 6'h0e;
    localparam int TXM_BIT_SYNTH_ON = 0;
    localparam int TXM_BIT_OSC_REG = 1;
    localparam int TXM_BIT_AMP_LO = 2;
    localparam int TXM_BIT_AMP_HI = 3;
    localparam int TXM_BIT_PD_REQ = 7;
    localparam logic [7:0] TXM_TX_CONTROL_RESET = 8'h00;
    // enable-low timeout, 2^16 crystal cycles
    localparam int TXM_TIMEOUT_CYCLES = 65536;
    // oscillator settling wait used by the host, in cycles
    localparam int TXM_SETTLE_CYCLES = 16;
    // baud generator period in crystal cycles
    localparam int TXM_BAUD_CYCLES = 16;
    // transmit command option bit: end synchronised to the bit edge
    localparam int TXM_OPT_SYNC_END = 0;
    // host command codes
    localparam logic [1:0] TXM_CMD_WRITE = 2'h0;
    localparam logic [1:0] TXM_CMD_READ = 2'h1;
    localparam logic [1:0] TXM_CMD_TX = 2'h2;
    // apb offsets of the host's own registers
    localparam logic [7:0] TXM_APB_CMD = 8'h00;
    localparam logic [7:0] TXM_APB_STATUS = 8'h04;
    localparam logic [7:0] TXM_APB_PIN = 8'h08;
    typedef enum logic [1:0] {
        TXM_POWER_DOWN,
        TXM_XTAL_ACTIVE,
        TXM_SYNTH_ACTIVE,
        TXM_TX_ACTIVE
    } txm_mode_type;
endpackage : txm_pkg
`default_nettype wire

/* File: design/txm_link_if.sv */
// interface joining the host end to the transmitter end
`default_nettype none
interface txm_link_if;
    logic en; // enable pin, host drives
    logic sck; // serial clock, host drives
    logic sdio_host_out; // host drive of data pin
    logic sdio_host_oe; // host drives data pin
    logic sdio_dev_out; // device drive of data pin
    logic sdio_dev_oe; // device drives data pin
    logic supply_fail; // brown-out event from supply monitor
    wire sdio = sdio_host_oe ? sdio_host_out : (sdio_dev_oe ? sdio_dev_out : 1'b0);
    modport device (input en, input sck, input sdio, input sdio_host_out, input supply_fail,
        output sdio_dev_out, output sdio_dev_oe);
    modport host (output en, output sck, output sdio_host_out, output sdio_host_oe, input sdio);
endinterface : txm_link_if
`default_nettype wire

/* File: design/txm_sync.sv */
// two-flop synchroniser with edge flags taken from the second flop
`default_nettype none
module txm_sync
    import txm_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pin side
    input wire logic pin,
    // synchronised level and edges
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta; // first flop, read only by level
    logic last; // previous level for edges

    // two flops, then edge detection on the clean copy
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta <= 1'b0;
            level <= 1'b0;
            last <= 1'b0;
        end
        else
        begin
            meta <= pin;
            level <= meta;
            last <= level;
        end
    end
    assign rise = level & ~last;
    assign fall = ~level & last;
endmodule : txm_sync
`default_nettype wire

/* File: design/txm_device.sv */
// transmitter mode controller: serial register access and mode sequencing
`default_nettype none
module txm_device
    import txm_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TXM_TIMEOUT_CYCLES
)
(
    // clock and reset (power-on reset)
    input wire logic clk,
    input wire logic rst,
    // link
    txm_link_if.device link,
    // analog controls
    output logic synth_power,
    output logic amp_enable,
    output logic osc_enable,
    output logic osc_regulated,
    output logic [1:0] amp_mode,
    output logic amp_unregulated,
    output logic mod_data,
    output logic baud_tick,
    output logic [1:0] mode_state
);
    txm_mode_type mode; // current operating mode
    logic [7:0] tx_control; // transmitter control register
    logic en_lvl, en_rise, en_fall, sck_lvl, sck_rise, sck_fall, sd_lvl, pf_lvl, pf_rise;
    logic [16:0] low_count; // enable-low timer
    logic timeout; // enable held low too long
    logic [3:0] bit_count; // serial bit counter
    logic [15:0] shift; // serial frame shift register
    logic frame_done; // 16 bits received
    logic [15:0] frame_in; // whole frame as its last bit is sampled
    logic tx_cmd; // a valid transmit command arrived
    logic sync_end; // transmit ends on a bit edge
    logic end_pending; // enable low seen, waiting bit edge
    logic streaming; // new data is sent from the data pin
    logic amp_started; // amplifier already on
    logic [7:0] baud_count; // baud generator phase
    logic [7:0] rd_data; // read shift out

    txm_sync u_en (.clk(clk), .rst(rst), .pin(link.en), .level(en_lvl), .rise(en_rise), .fall(en_fall));
    txm_sync u_sck (.clk(clk), .rst(rst), .pin(link.sck), .level(sck_lvl), .rise(sck_rise), .fall(sck_fall));
    txm_sync u_sd (.clk(clk), .rst(rst), .pin(link.sdio), .level(sd_lvl), .rise(), .fall());
    txm_sync u_pf (.clk(clk), .rst(rst), .pin(link.supply_fail), .level(pf_lvl), .rise(pf_rise), .fall());

    // enable-low timer restarts while enable is high
    always_ff @(posedge clk)
    begin
        if (rst || en_lvl)
            low_count <= '0;
        else if (!timeout)
            low_count <= low_count + 17'd1;
    end
    // gated by the level so the rising edge that ends power-down is not swallowed by the timeout
    assign timeout = (low_count == 17'(TIMEOUT_CYCLES)) && !en_lvl;

    // serial receive: 2-bit command, 6 address bits, 8 data bits, on sck rise
    always_ff @(posedge clk)
    begin
        if (rst || timeout || mode == TXM_POWER_DOWN || !en_lvl)
        begin
            bit_count <= '0;
            shift <= '0;
        end
        else if (sck_rise && !streaming)
        begin
            shift <= {shift[14:0], sd_lvl};
            bit_count <= bit_count + 4'd1;
        end
    end
    assign frame_done = sck_rise && !streaming && en_lvl && bit_count == 4'hf && mode != TXM_POWER_DOWN;
    assign frame_in = {shift[14:0], sd_lvl}; // bit 0 is still on the pin at frame end
    assign tx_cmd = frame_done && shift[14:13] == TXM_CMD_TX && tx_control[TXM_BIT_SYNTH_ON];

    // read data out on sck fall after the address byte
    always_ff @(posedge clk)
    begin
        if (rst || !en_lvl)
        begin
            rd_data <= '0;
            link.sdio_dev_oe <= 1'b0;
            link.sdio_dev_out <= 1'b0;
        end
        else if (sck_rise && bit_count == 4'h7 && shift[6:5] == TXM_CMD_READ)
        begin
            rd_data <= ({shift[4:0], sd_lvl} == TXM_ADDR_TX_CONTROL) ? tx_control : 8'h00;
            link.sdio_dev_oe <= 1'b1;
        end
        else if (sck_fall && link.sdio_dev_oe)
        begin
            link.sdio_dev_out <= rd_data[7];
            rd_data <= {rd_data[6:0], 1'b0};
        end
    end

    // control register: writes, hardware clears
    always_ff @(posedge clk)
    begin
        if (rst)
            tx_control <= TXM_TX_CONTROL_RESET;
        else
        begin
            if (frame_done && shift[14:13] == TXM_CMD_WRITE && shift[12:7] == TXM_ADDR_TX_CONTROL)
                tx_control <= {shift[6:0], sd_lvl};
            if (timeout)
                tx_control[TXM_BIT_SYNTH_ON] <= 1'b0;
            if (mode == TXM_TX_ACTIVE && amp_started && pf_rise)
                tx_control[TXM_BIT_SYNTH_ON] <= 1'b0;
            if (mode == TXM_POWER_DOWN && en_rise)
                tx_control[TXM_BIT_PD_REQ] <= 1'b0;
        end
    end

    // mode sequencer; power-on reset drops to crystal mode
    always_ff @(posedge clk)
    begin
        if (rst)
            mode <= TXM_XTAL_ACTIVE;
        else if (timeout || tx_control[TXM_BIT_PD_REQ] && mode != TXM_POWER_DOWN)
            mode <= TXM_POWER_DOWN;
        else
        begin
            unique case (mode)
                TXM_POWER_DOWN:
                    if (en_rise)
                        mode <= TXM_XTAL_ACTIVE;
                TXM_XTAL_ACTIVE:
                    if (tx_control[TXM_BIT_SYNTH_ON])
                        mode <= TXM_SYNTH_ACTIVE;
                TXM_SYNTH_ACTIVE:
                    if (!tx_control[TXM_BIT_SYNTH_ON])
                        mode <= TXM_XTAL_ACTIVE;
                    else if (tx_cmd)
                        mode <= TXM_TX_ACTIVE;
                TXM_TX_ACTIVE:
                    if (!tx_control[TXM_BIT_SYNTH_ON])
                        mode <= TXM_XTAL_ACTIVE;
                    else if (streaming && en_fall && !sync_end)
                        mode <= TXM_SYNTH_ACTIVE;
                    else if (end_pending && baud_tick)
                        mode <= TXM_SYNTH_ACTIVE;
            endcase
        end
    end

    // transmit streaming, interruption and options
    always_ff @(posedge clk)
    begin
        if (rst || mode != TXM_TX_ACTIVE && !tx_cmd)
        begin
            streaming <= 1'b0;
            sync_end <= 1'b0;
            end_pending <= 1'b0;
            amp_started <= 1'b0;
        end
        else if (tx_cmd)
        begin
            streaming <= 1'b1;
            sync_end <= frame_in[TXM_OPT_SYNC_END];
            end_pending <= 1'b0;
            amp_started <= 1'b1;
        end
        else if (streaming && en_fall)
        begin
            streaming <= 1'b0;
            end_pending <= sync_end;
        end
        else if (en_rise)
            end_pending <= 1'b0;
    end

    // modulator data: samples the data pin at each baud tick while streaming, latched on enable fall
    always_ff @(posedge clk)
    begin
        if (rst || mode == TXM_POWER_DOWN)
            mod_data <= 1'b0;
        else if (streaming && en_fall)
            mod_data <= sd_lvl;
        else if (streaming && baud_tick)
            mod_data <= sd_lvl;
    end

    // baud generator: reset at first string only, free running across resumes
    always_ff @(posedge clk)
    begin
        if (rst || (tx_cmd && !amp_started) || mode != TXM_TX_ACTIVE && !tx_cmd)
            baud_count <= '0;
        else if (baud_count == 8'(TXM_BAUD_CYCLES - 1))
            baud_count <= '0;
        else
            baud_count <= baud_count + 8'd1;
    end

    // registered analog controls
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            synth_power <= 1'b0;
            amp_enable <= 1'b0;
            osc_enable <= 1'b1;
            osc_regulated <= 1'b0;
            amp_mode <= 2'h0;
            amp_unregulated <= 1'b0;
            baud_tick <= 1'b0;
            mode_state <= 2'h0;
        end
        else
        begin
            synth_power <= mode == TXM_SYNTH_ACTIVE || mode == TXM_TX_ACTIVE;
            amp_enable <= mode == TXM_TX_ACTIVE && amp_started;
            osc_enable <= mode != TXM_POWER_DOWN;
            osc_regulated <= tx_control[TXM_BIT_OSC_REG] && mode == TXM_TX_ACTIVE;
            amp_mode <= tx_control[TXM_BIT_AMP_HI:TXM_BIT_AMP_LO];
            amp_unregulated <= &tx_control[TXM_BIT_AMP_HI:TXM_BIT_AMP_LO];
            // gated by the mode so no tick trails a direct exit from transmit
            baud_tick <= baud_count == 8'(TXM_BAUD_CYCLES - 2) && mode == TXM_TX_ACTIVE;
            mode_state <= mode;
        end
    end
endmodule : txm_device
`default_nettype wire

/* File: design/txm_host.sv */
// host end: apb slave registers drive enable and serial frames toward the transmitter
`default_nettype none
module txm_host
    import txm_pkg::*;
#(
    parameter int HALF_CYCLES = 4
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // link
    txm_link_if.host link
);
    logic [15:0] frame; // frame being sent
    logic [4:0] bits_left; // bits still to clock
    logic [7:0] half_count; // sck half period timer
    logic [7:0] rx; // read data captured
    logic busy; // frame in progress
    logic sd_meta, sd_lvl; // data pin synchroniser
    logic [7:0] settle; // oscillator settling wait after enable rises
    logic access; // apb access phase
    logic [1:0] op; // command code of the frame in flight

    assign access = psel && penable;

    // data pin sync
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sd_meta <= 1'b0;
            sd_lvl <= 1'b0;
        end
        else
        begin
            sd_meta <= link.sdio;
            sd_lvl <= sd_meta;
        end
    end

    // apb answer in the access cycle; busy shows in status
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && paddr != TXM_APB_CMD && paddr != TXM_APB_STATUS && paddr != TXM_APB_PIN;
            prdata <= (paddr == TXM_APB_STATUS) ? {23'h0, (settle != 8'h00) || busy, rx} : 32'h0;
        end
    end

    // pins and frame engine
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            link.en <= 1'b0;
            link.sck <= 1'b0;
            link.sdio_host_out <= 1'b0;
            link.sdio_host_oe <= 1'b0;
            frame <= '0;
            bits_left <= '0;
            half_count <= '0;
            busy <= 1'b0;
            rx <= '0;
            settle <= '0;
            op <= 2'h0;
        end
        else
        begin
            if (settle != 8'h00)
                settle <= settle - 8'd1;
            if (access && pwrite && paddr == TXM_APB_PIN)
            begin
                link.en <= pwdata[0];
                link.sdio_host_out <= pwdata[1];
                link.sdio_host_oe <= pwdata[2];
                if (pwdata[0] && !link.en)
                    settle <= 8'(TXM_SETTLE_CYCLES);
            end
            else if (access && pwrite && paddr == TXM_APB_CMD && !busy && settle == 8'h00)
            begin
                frame <= pwdata[15:0];
                op <= pwdata[15:14];
                bits_left <= 5'd16;
                busy <= 1'b1;
                half_count <= '0;
                link.sdio_host_oe <= 1'b1;
                link.sdio_host_out <= pwdata[15];
            end
            else if (busy)
            begin
                if (half_count == 8'(HALF_CYCLES - 1))
                begin
                    half_count <= '0;
                    link.sck <= ~link.sck;
                    if (link.sck)
                    begin
                        bits_left <= bits_left - 5'd1;
                        if (bits_left == 5'd1)
                        begin
                            busy <= 1'b0;
                            // after a transmit command the host keeps driving the data stream
                            link.sdio_host_oe <= op == TXM_CMD_TX;
                        end
                        else
                            link.sdio_host_out <= frame[14];
                        frame <= {frame[14:0], 1'b0};
                        // read bits are taken just before sck falls: the trip through both
                        // synchronisers is longer than half an sck period
                        if (bits_left <= 5'd8)
                            rx <= {rx[6:0], sd_lvl};
                        // release the data pin once the last address bit has been sampled
                        if (bits_left <= 5'd9 && op == TXM_CMD_READ)
                            link.sdio_host_oe <= 1'b0;
                    end
                end
                else
                    half_count <= half_count + 8'd1;
            end
        end
    end
endmodule : txm_host
`default_nettype wire

/* File: verif/txm_link_properties.sv */
// concurrent checks on the link and the transmitter end's mode outputs
`default_nettype none
module txm_link_properties
    import txm_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = 64 // enable-low limit in clk cycles
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // link
    input wire logic en,
    input wire logic supply_fail,
    // transmitter end outputs
    input wire logic synth_power,
    input wire logic amp_enable,
    input wire logic osc_regulated,
    input wire logic [1:0] amp_mode,
    input wire logic amp_unregulated,
    input wire logic mod_data,
    input wire logic baud_tick,
    input wire logic [1:0] mode_state
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    int low_cnt; // cycles of enable low, saturating
    logic [3:0] since_tick; // cycles since the last baud tick, wraps at 16
    logic tick_seen; // a tick was seen in this transmit stretch
    // enable-low time; saturates so the count cannot wrap back under the limit
    always_ff @(posedge clk)
    begin
        if (rst || en)
            low_cnt <= 0;
        else if (low_cnt < TIMEOUT_CYCLES + 9)
            low_cnt <= low_cnt + 1;
    end
    // baud phase; forgotten outside transmit since a new stretch may restart it
    always_ff @(posedge clk)
    begin
        since_tick <= baud_tick ? 4'h0 : since_tick + 4'h1;
        if (rst || mode_state != 2'd3)
            tick_seen <= 1'b0;
        else if (baud_tick)
            tick_seen <= 1'b1;
    end
    // settled power-down
    sequence s_pd_hold;
        (mode_state == 2'd0) [*2];
    endsequence
    // enable held low in transmit, short of the timeout
    sequence s_tx_low;
        (!en && mode_state == 2'd3) [*5] ##0 (low_cnt < TIMEOUT_CYCLES);
    endsequence
    a_timeout_power_down: assert property (low_cnt == TIMEOUT_CYCLES + 8 |-> mode_state == 2'd0)
        else $error("enable-low timeout did not give power-down");
    a_pd_all_off: assert property (s_pd_hold |-> !synth_power && !amp_enable && !osc_regulated)
        else $error("power-down with synthesizer or amplifier on");
    a_wake_to_crystal: assert property (mode_state == 2'd0 && $rose(en) |-> ##[1:6] mode_state == 2'd1)
        else $error("enable rise did not leave power-down");
    a_tx_from_synth: assert property ($changed(mode_state) && mode_state == 2'd3 |-> $past(mode_state) == 2'd2)
        else $error("transmit entered from other than synth mode");
    a_amp_unreg_on: assert property ((amp_mode == 2'd3) [*2] |-> amp_unregulated)
        else $error("mode 3 kept stabilization");
    a_amp_reg_on: assert property ((amp_mode != 2'd3) [*2] |-> !amp_unregulated)
        else $error("regulated mode lost stabilization");
    a_osc_reg_tx: assert property ($rose(osc_regulated) |-> ##[0:2] mode_state == 2'd3)
        else $error("regulated oscillator supply outside transmit");
    a_osc_unreg_idle: assert property ((mode_state != 2'd3) [*3] |-> !osc_regulated)
        else $error("regulated oscillator supply kept after transmit");
    a_baud_in_tx: assert property (baud_tick |-> mode_state == 2'd3)
        else $error("baud tick outside transmit");
    a_baud_phase: assert property (baud_tick && tick_seen |-> since_tick == 4'hf)
        else $error("baud tick out of phase");
    a_supply_drop: assert property (mode_state == 2'd3 && $rose(supply_fail)
        |-> ##[1:6] (mode_state == 2'd1 && !synth_power))
        else $error("supply drop did not stop transmit");
    a_data_frozen: assert property (s_tx_low |-> $stable(mod_data))
        else $error("modulator bit moved while enable low");
endmodule : txm_link_properties
`default_nettype wire

/* File: verif/tx_mode_controller_test.sv */
// self-checking bench: host end over apb drives the transmitter end through the link
`default_nettype none
`define CHK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin n_fail++; \
    $display("Error %s expected %h seen %h", what, exp, got); end end
module tx_mode_controller_test
    import txm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TOUT = 64; // short enable-low limit keeps the run brief
    logic clk, rst; // clock and synchronous reset
    logic psel, penable, pwrite, pready, pslverr; // apb
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic synth_power, amp_enable, osc_enable, osc_regulated, amp_unregulated, mod_data, baud_tick;
    logic [1:0] amp_mode, mode_state;
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;
    int m; // amplifier mode loop
    logic [31:0] q; // last read data
    logic e; // last slave error
    txm_link_if link();
    txm_host u_txm_host (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.host));
    txm_device #(.TIMEOUT_CYCLES(TOUT)) u_txm_device (.clk(clk), .rst(rst), .link(link.device),
        .synth_power(synth_power), .amp_enable(amp_enable), .osc_enable(osc_enable),
        .osc_regulated(osc_regulated), .amp_mode(amp_mode), .amp_unregulated(amp_unregulated),
        .mod_data(mod_data), .baud_tick(baud_tick), .mode_state(mode_state));
    txm_link_properties #(.TIMEOUT_CYCLES(TOUT)) u_txm_link_properties (.clk(clk), .rst(rst),
        .en(link.en), .supply_fail(link.supply_fail), .synth_power(synth_power), .amp_enable(amp_enable),
        .osc_regulated(osc_regulated), .amp_mode(amp_mode), .amp_unregulated(amp_unregulated),
        .mod_data(mod_data), .baud_tick(baud_tick), .mode_state(mode_state));
    // 40 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // hang guard, well above the few thousand cycles the sequence needs
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            n_fail++;
            test_done();
        end
    end
    // verdict and end of run
    task automatic test_done();
        $display("mismatches %0d comparisons %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // poll until the host is neither settling nor framing
    task automatic idle();
        q = 32'h100;
        while (q[8] !== 1'b0)
            apb(1'b0, TXM_APB_STATUS, 32'h0);
    endtask : idle
    // one serial frame; a write while busy would be dropped, so wait both sides
    task automatic cmd(input logic [15:0] f);
        repeat (2) @(posedge clk);
        idle();
        apb(1'b1, TXM_APB_CMD, {16'h0, f});
        repeat (2) @(posedge clk);
        idle();
    endtask : cmd
    // pin register: bit 0 enable, bit 1 data value, bit 2 data drive
    task automatic pin(input logic [2:0] p);
        apb(1'b1, TXM_APB_PIN, {29'h0, p});
    endtask : pin
    // control register write and read over the serial link
    task automatic wr_ctl(input logic [7:0] v);
        cmd({2'b00, TXM_ADDR_TX_CONTROL, v});
    endtask : wr_ctl
    task automatic rd_ctl();
        cmd({2'b01, TXM_ADDR_TX_CONTROL, 8'h00});
        apb(1'b0, TXM_APB_STATUS, 32'h0);
    endtask : rd_ctl
    // bounded wait for a mode, then compare
    task automatic wm(input logic [1:0] s);
        int i;
        for (i = 0; i < 400 && mode_state !== s; i++)
            @(posedge clk);
        `CHK("mode", s, mode_state)
    endtask : wm
    // bounded wait just past a baud tick
    task automatic tick();
        int i;
        for (i = 0; i < 100 && baud_tick !== 1'b1; i++)
            @(posedge clk);
        @(posedge clk);
    endtask : tick
    // main sequence
    initial
    begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        link.supply_fail = 1'b0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        wm(2'd1);
        wm(2'd0);
        `CHK("osc_enable", 1'b0, osc_enable)
        pin(3'b001);
        wm(2'd1);
        `CHK("osc_enable", 1'b1, osc_enable)
        rd_ctl();
        `CHK("control", 8'h00, q[7:0])
        for (m = 0; m < 4; m++)
        begin
            wr_ctl({4'h0, m[1:0], 2'b01});
            wm(2'd2);
            `CHK("amp_mode", m[1:0], amp_mode)
            `CHK("amp_unregulated", (m == 3), amp_unregulated)
            rd_ctl();
            `CHK("control", {4'h0, m[1:0], 2'b01}, q[7:0])
        end
        // short enable-low keeps synth mode
        pin(3'b000);
        repeat (30) @(posedge clk);
        pin(3'b001);
        wm(2'd2);
        wr_ctl(8'h00);
        wm(2'd1);
        `CHK("synth_power", 1'b0, synth_power)
        // transmit refused with the synthesizer off
        cmd(16'h8000);
        `CHK("mode", 2'd1, mode_state)
        wr_ctl(8'h03);
        wm(2'd2);
        pin(3'b111);
        cmd(16'h8000);
        wm(2'd3);
        pin(3'b111);
        `CHK("amp_enable", 1'b1, amp_enable)
        `CHK("osc_regulated", 1'b1, osc_regulated)
        tick();
        tick();
        `CHK("mod_data", 1'b1, mod_data)
        pin(3'b110);
        wm(2'd2);
        `CHK("osc_regulated", 1'b0, osc_regulated)
        pin(3'b111);
        // synchronised end; short enable pulse opens access during transmit
        cmd(16'h8001);
        wm(2'd3);
        tick();
        pin(3'b110);
        pin(3'b111);
        wr_ctl(8'h05);
        `CHK("mode", 2'd3, mode_state)
        `CHK("mod_data", 1'b1, mod_data)
        `CHK("amp_mode", 2'd1, amp_mode)
        pin(3'b101);
        cmd(16'h8001);
        pin(3'b101);
        tick();
        tick();
        `CHK("mod_data", 1'b0, mod_data)
        pin(3'b100);
        wm(2'd2);
        pin(3'b101);
        // supply drop in transmit, then restart
        cmd(16'h8000);
        wm(2'd3);
        link.supply_fail <= 1'b1;
        wm(2'd1);
        `CHK("synth_power", 1'b0, synth_power)
        link.supply_fail <= 1'b0;
        rd_ctl();
        `CHK("control", 8'h04, q[7:0])
        wr_ctl(8'h05);
        wm(2'd2);
        cmd(16'h8000);
        wm(2'd3);
        // long enable-low in transmit
        pin(3'b000);
        wm(2'd0);
        `CHK("amp_enable", 1'b0, amp_enable)
        pin(3'b001);
        wm(2'd1);
        rd_ctl();
        `CHK("synth bit", 1'b0, q[0])
        // power-down request from synth mode
        wr_ctl(8'h05);
        wm(2'd2);
        wr_ctl(8'h80);
        wm(2'd0);
        pin(3'b000);
        pin(3'b001);
        wm(2'd1);
        rd_ctl();
        `CHK("control", 8'h00, q[7:0])
        // unmapped offset
        apb(1'b0, 8'h0c, 32'h0);
        `CHK("pslverr", 1'b1, e)
        test_done();
    end
endmodule : tx_mode_controller_test
`default_nettype wire
